// ### exc_map.svh
`ifndef EXC_MAP_SVH
`define EXC_MAP_SVH

// Vector numbers of the exception table.
`define VEC_RESET 6'd0
`define VEC_NMI 6'd7
`define VEC_TRAP_BASE 6'd8
`define VEC_IRQ_BASE 6'd12
`define VEC_INT_BASE 6'd20
`define VEC_INT_LAST 6'd60
// Each entry is four bytes wide.
`define VEC_ENTRY_SHIFT 2
// Number of maskable external lines and internal sources.
`define NUM_IRQ 6
`define NUM_INT 30
// Flag register bit positions and reset value.
`define FLAG_I_BIT 7
`define FLAG_UI_BIT 6
`define FLAGS_RESET 8'h80

`endif

// ### exc_pkg.sv
package exc_pkg;
  typedef enum logic [2:0] {
    ST_HOLD, ST_RESET_MASK, ST_RUN, ST_PUSH_PC, ST_PUSH_FLAGS, ST_MASK, ST_VECTOR
  } exc_state_e;

  // Stack push request towards the datapath.
  typedef struct packed {
    logic valid;
    logic is_flags;
  } push_req_s;

  // Vector fetch request towards the fetch unit.
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } vec_req_s;
endpackage : exc_pkg

// ### exc_source_select.sv
`timescale 1ns/1ps
`include "exc_map.svh"

// Chooses the winning interrupt source and its vector number.
module exc_source_select (
  // Request lines
  input wire logic nmi_req,
  input wire logic [`NUM_IRQ-1:0] irq_req,
  input wire logic [`NUM_INT-1:0] int_req,
  input wire logic [`NUM_INT*6-1:0] int_vec,
  // Result
  output logic any_req,
  output logic [5:0] vec_num
);
  logic [5:0] irq_vec;
  logic [5:0] int_sel;
  logic irq_any;
  logic int_any;

  // Lowest numbered line wins within each group.
  always_comb begin
    irq_vec = `VEC_IRQ_BASE;
    irq_any = 1'b0;
    for (int i = `NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_req[i]) begin
        irq_vec = `VEC_IRQ_BASE + 6'(i);
        irq_any = 1'b1;
      end
    end
    int_sel = `VEC_INT_BASE;
    int_any = 1'b0;
    for (int j = `NUM_INT - 1; j >= 0; j--) begin
      if (int_req[j]) begin
        int_sel = int_vec[j*6 +: 6];
        int_any = 1'b1;
      end
    end
  end

  // The nonmaskable request outranks external lines, which outrank internal ones.
  assign any_req = nmi_req | irq_any | int_any;
  assign vec_num = nmi_req ? `VEC_NMI : (irq_any ? irq_vec : int_sel);
endmodule : exc_source_select

// ### exception_priority_vectoring.sv
`timescale 1ns/1ps
`include "exc_map.svh"

module exception_priority_vectoring
  import exc_pkg::*;
(
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Reset pin, active low, asynchronous to ref_clk
  input wire logic reset_pin_n,
  // Interrupt sources, already synchronised by the interrupt controller
  input wire logic nmi_req,
  input wire logic [`NUM_IRQ-1:0] irq_req,
  input wire logic [`NUM_INT-1:0] int_req,
  input wire logic [`NUM_INT*6-1:0] int_vec,
  // Core pipeline side
  input wire logic insn_done,
  input wire logic trap_instruction,
  input wire logic [1:0] trap_num,
  input wire logic user_bit_enable,
  input wire logic [7:0] flags_in,
  input wire logic step_ack,
  // Datapath requests
  output push_req_s push_req,
  output vec_req_s vec_req,
  output logic [7:0] condition_flags_register,
  output logic exc_busy,
  output logic core_halt
);
  // ------------------------------------------------------------------
  // Sequencer state and working signals
  // ------------------------------------------------------------------
  exc_state_e state_r, state_nxt;
  logic rst_meta_r, rst_sync_r, rst_prev_r;
  logic [7:0] flags_r, flags_nxt;
  logic [5:0] vec_r, vec_nxt;
  logic trap_r, trap_nxt;
  logic first_done_r, first_done_nxt;
  logic int_any;
  logic [5:0] int_vec_num;
  logic pin_rise, pin_low, int_take, trap_take;

  // ------------------------------------------------------------------
  // Reset pin synchroniser
  // ------------------------------------------------------------------
  // The pin is asynchronous, so no logic reads the first stage directly.
  // Two-stage synchroniser for the reset pin; edges are seen on the second stage.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
      rst_prev_r <= 1'b0;
    end else if (clk_en) begin
      rst_meta_r <= reset_pin_n;
      rst_sync_r <= rst_meta_r;
      rst_prev_r <= rst_sync_r;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt source selection
  // ------------------------------------------------------------------
  // The selector is purely combinational; the number is captured on the take.
  exc_source_select exc_source_select_i (
    .nmi_req(nmi_req),
    .irq_req(irq_req),
    .int_req(int_req),
    .int_vec(int_vec),
    .any_req(int_any),
    .vec_num(int_vec_num)
  );

  // ------------------------------------------------------------------
  // Acceptance decode
  // ------------------------------------------------------------------
  // reset edge detect.
  assign pin_rise = rst_sync_r & ~rst_prev_r;
  assign pin_low = ~rst_sync_r;
  // boundary gating; block until first instruction done.
  // The mask bit only gates maskable sources; the nonmaskable one bypasses it.
  assign int_take = insn_done & first_done_r &
                    (nmi_req | (int_any & ~flags_in[`FLAG_I_BIT]));
  // Traps need no boundary, since the decoded trap itself ends its instruction.
  // unmasked trap acceptance; loses to an interrupt.
  assign trap_take = trap_instruction & ~int_take;

  // ------------------------------------------------------------------
  // Sequencer next state
  // ------------------------------------------------------------------
  // Next-state logic of the exception sequencer.
  always_comb begin
    state_nxt = state_r;
    flags_nxt = flags_r;
    vec_nxt = vec_r;
    trap_nxt = trap_r;
    first_done_nxt = first_done_r;
    case (state_r)
      ST_HOLD: begin
        // begin on rising edge.
        // A pin already high when srst ends counts as a rise, as the flops reset low.
        if (pin_rise) begin
          state_nxt = ST_RESET_MASK;
        end
      end
      ST_RESET_MASK: begin
        flags_nxt = flags_r | (8'h01 << `FLAG_I_BIT);
        vec_nxt = `VEC_RESET;
        trap_nxt = 1'b0;
        first_done_nxt = 1'b0;
        state_nxt = ST_VECTOR;
      end
      ST_RUN: begin
        flags_nxt = flags_in;
        if (insn_done) begin
          first_done_nxt = 1'b1;
        end
        if (int_take) begin
          vec_nxt = int_vec_num;
          trap_nxt = 1'b0;
          state_nxt = ST_PUSH_PC;
        end else if (trap_take) begin
          vec_nxt = `VEC_TRAP_BASE + {4'h0, trap_num};
          trap_nxt = 1'b1;
          state_nxt = ST_PUSH_PC;
        end
      end
      ST_PUSH_PC: begin
        if (step_ack) begin
          state_nxt = ST_PUSH_FLAGS;
        end
      end
      ST_PUSH_FLAGS: begin
        if (step_ack) begin
          state_nxt = ST_MASK;
        end
      end
      ST_MASK: begin
        // The user bit acts as a second mask level only while user bits are disabled.
        // set mask; user mask on trap.
        flags_nxt = flags_r | (8'h01 << `FLAG_I_BIT);
        if (trap_r && !user_bit_enable) begin
          flags_nxt = flags_nxt | (8'h01 << `FLAG_UI_BIT);
        end
        state_nxt = ST_VECTOR;
      end
      ST_VECTOR: begin
        if (step_ack) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_HOLD;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Sequencer registers
  // ------------------------------------------------------------------
  // The pin override sits here and not in the case, so every state obeys it.
  // Sequencer registers. A low reset pin forces the hold state at any time.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= ST_HOLD;
      flags_r <= `FLAGS_RESET;
      vec_r <= `VEC_RESET;
      trap_r <= 1'b0;
      first_done_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= pin_low ? ST_HOLD : state_nxt;
      flags_r <= flags_nxt;
      vec_r <= vec_nxt;
      trap_r <= trap_nxt;
      first_done_r <= pin_low ? 1'b0 : first_done_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Datapath requests
  // ------------------------------------------------------------------
  // Requests decode the state, so they drop in the cycle after the acknowledge.
  // The address comes from the registered number and stays stable while valid stands.
  // Datapath requests. low 16 bits; number times four.
  assign push_req.valid = (state_r == ST_PUSH_PC) | (state_r == ST_PUSH_FLAGS);
  assign push_req.is_flags = (state_r == ST_PUSH_FLAGS);
  assign vec_req.valid = (state_r == ST_VECTOR);
  assign vec_req.addr = {8'h00, vec_r, 2'b00};
  assign condition_flags_register = flags_r;
  assign exc_busy = (state_r != ST_RUN);
  assign core_halt = (state_r == ST_HOLD) | (state_r == ST_RESET_MASK);
endmodule : exception_priority_vectoring

// ### exc_checker.sv
`timescale 1ns/1ps
module exc_checker
  import exc_pkg::*;
(
  // Watched ports
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic reset_pin_n,
  input wire logic insn_done,
  input wire logic trap_instruction,
  input wire logic step_ack,
  input push_req_s push_req,
  input vec_req_s vec_req,
  input wire logic [7:0] condition_flags_register,
  input wire logic exc_busy,
  input wire logic core_halt
);
  // The pin must have been high across the synchroniser span, else a reset may be on its way.
  logic [2:0] pin_r;
  always_ff @(posedge ref_clk) pin_r <= {pin_r[1:0], reset_pin_n};
  wire pin_ok = reset_pin_n && (&pin_r);
  wire flags_ack = push_req.valid && push_req.is_flags && step_ack;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_push_order: assert property (
    push_req.valid && !push_req.is_flags && step_ack |=> push_req.valid && push_req.is_flags)
    else $error("flags push does not follow pc push");
  a_mask_set: assert property (flags_ack |=> ##[1:2] condition_flags_register[7])
    else $error("mask bit not set after push");
  a_vector_last: assert property (flags_ack |=> ##1 vec_req.valid)
    else $error("vector fetch not after mask step");
  a_vec_align: assert property (
    vec_req.valid |-> vec_req.addr[1:0] == 2'h0 && vec_req.addr[15:8] == 8'h00)
    else $error("vector address misformed");
  a_vec_reserved: assert property (
    vec_req.valid |-> !(vec_req.addr[7:2] inside {[6'h01:6'h06], 6'h12, 6'h13}))
    else $error("reserved vector used");
  a_reset_vector: assert property ($fell(core_halt) |-> vec_req.valid &&
    vec_req.addr == 16'h0000 && !push_req.valid && condition_flags_register[7])
    else $error("reset vector step wrong");
  a_pin_halt: assert property (!reset_pin_n [*4] |=> core_halt)
    else $error("low pin does not halt");
  a_run_hold: assert property (
    !exc_busy && !insn_done && !trap_instruction && pin_ok |=> !exc_busy)
    else $error("exception taken off a boundary");
  a_trap_take: assert property (
    !exc_busy && trap_instruction && pin_ok |=> push_req.valid && !push_req.is_flags)
    else $error("trap not accepted");
  c_reset: cover property ($fell(core_halt));
  c_trap: cover property (!exc_busy && trap_instruction);
  c_flags: cover property (flags_ack);
endmodule : exc_checker
bind exception_priority_vectoring exc_checker exc_checker_i (.ref_clk, .srst, .reset_pin_n,
  .insn_done, .trap_instruction, .step_ack, .push_req, .vec_req, .condition_flags_register,
  .exc_busy, .core_halt);

// ### core_step_model.sv
`timescale 1ns/1ps
module core_step_model
  import exc_pkg::*;
(
  // Clock, reset and pacing
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [3:0] lat,
  // Requests and answer
  input push_req_s push_req,
  input vec_req_s vec_req,
  output logic step_ack
);
  logic [3:0] wait_r;
  // One-cycle acknowledge after lat cycles, so a held request is never counted twice.
  always_ff @(posedge ref_clk) begin
    if (srst || step_ack || !(push_req.valid || vec_req.valid)) begin
      wait_r <= 4'h0;
      step_ack <= 1'b0;
    end else if (wait_r >= lat) begin
      step_ack <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule : core_step_model

// ### tb_exception_priority_vectoring.sv
`timescale 1ns/1ps
module tb_exception_priority_vectoring
  import exc_pkg::*;
;
  logic ref_clk, srst, reset_pin_n, nmi_req, insn_done, trap_instruction, user_bit_enable;
  logic step_ack, exc_busy, core_halt;
  logic [5:0] irq_req;
  logic [29:0] int_req;
  logic [179:0] int_vec;
  logic [1:0] trap_num;
  logic [7:0] flags_in, condition_flags_register;
  logic [3:0] lat;
  push_req_s push_req;
  vec_req_s vec_req;
  int num_errors = 0;
  int total_checks = 0;
  exception_priority_vectoring exception_priority_vectoring_i (.ref_clk, .srst, .clk_en(1'b1),
    .reset_pin_n, .nmi_req, .irq_req, .int_req, .int_vec, .insn_done, .trap_instruction,
    .trap_num, .user_bit_enable, .flags_in, .step_ack, .push_req, .vec_req,
    .condition_flags_register, .exc_busy, .core_halt);
  core_step_model core_step_model_i (.ref_clk, .srst, .lat, .push_req, .vec_req, .step_ack);
  task check(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : check
  task stop_test;
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // Presents requests at one instruction boundary.
  task take(input logic n, input logic [5:0] irq, input logic [29:0] in, input logic tr,
    input logic [1:0] tn, input logic ue);
    @(posedge ref_clk) #1;
    {nmi_req, irq_req, int_req} = {n, irq, in};
    {trap_instruction, trap_num, user_bit_enable} = {tr, tn, ue};
    insn_done = 1'b1;
    @(posedge ref_clk) #1;
    insn_done = 1'b0;
    trap_instruction = 1'b0;
  endtask : take
  // Counts acknowledged pushes until the vector fetch, then judges the sequence.
  task run(input logic [15:0] exp, input int np, input logic ue0);
    int n;
    n = 0;
    repeat (60) begin
      @(negedge ref_clk);
      if (push_req.valid && step_ack) n++;
      if (vec_req.valid && step_ack) break;
    end
    check(16'(vec_req.valid), 16'h1, "vector fetch");
    check(vec_req.addr, exp, "vector address");
    check(16'(n), 16'(np), "push count");
    check(16'(condition_flags_register[7]), 16'h1, "mask bit");
    check(16'(condition_flags_register[6]), 16'(ue0), "user mask");
    @(posedge ref_clk) #1;
    {nmi_req, irq_req, int_req} = '0;
    repeat (2) @(posedge ref_clk);
  endtask : run
  // A request that must be ignored leaves the core running.
  task refuse(input logic n, input logic [5:0] irq);
    take(n, irq, 30'h0, 1'b0, 2'h0, 1'b1);
    repeat (4) begin
      @(negedge ref_clk);
      check(16'(exc_busy), 16'h0, "refused request");
    end
    @(posedge ref_clk) #1;
    {nmi_req, irq_req} = '0;
  endtask : refuse
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #100us;
    num_errors++;
    stop_test();
  end
  initial begin
    {srst, reset_pin_n, nmi_req, irq_req, int_req, insn_done, trap_instruction} = '0;
    srst = 1'b1;
    {trap_num, user_bit_enable, flags_in, lat} = '0;
    for (int j = 0; j < 30; j++) int_vec[j*6+:6] = 6'(20 + j);
    repeat (10) @(posedge ref_clk);
    #1 srst = 1'b0;
    reset_pin_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    check(16'(core_halt), 16'h1, "halt while pin low");
    @(posedge ref_clk);
    #1 reset_pin_n = 1'b1;
    run(16'h0000, 0, 1'b0);
    refuse(1'b1, 6'h00);
    take(1'b1, 6'h3F, 30'h1, 1'b1, 2'h0, 1'b1);
    run(16'h001C, 2, 1'b0);
    take(1'b0, 6'h3F, 30'h3FFFFFFF, 1'b1, 2'h1, 1'b1);
    run(16'h0030, 2, 1'b0);
    lat = 4'h3;
    for (int i = 0; i < 6; i++) begin
      take(1'b0, 6'(1 << i), 30'h0, 1'b0, 2'h0, 1'b1);
      run(16'(16'h30 + 4 * i), 2, 1'b0);
    end
    lat = 4'h0;
    for (int j = 0; j < 30; j += 29) begin
      take(1'b0, 6'h00, 30'h1 << j, 1'b0, 2'h0, 1'b1);
      run(16'((20 + j) * 4), 2, 1'b0);
    end
    flags_in = 8'h80;
    refuse(1'b0, 6'h3F);
    for (int t = 0; t < 4; t++) begin
      take(1'b0, 6'h3F, 30'h0, 1'b1, 2'(t), 1'(t));
      run(16'(16'h20 + 4 * t), 2, !1'(t));
    end
    // A second reset in mid-run restarts the sequence and blocks interrupts again.
    @(posedge ref_clk) #1;
    reset_pin_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    check(16'(core_halt), 16'h1, "halt after mid-run pin low");
    @(posedge ref_clk) #1;
    reset_pin_n = 1'b1;
    run(16'h0000, 0, 1'b0);
    refuse(1'b1, 6'h00);
    stop_test();
  end
endmodule : tb_exception_priority_vectoring
